// ---- core/low_power_mode_controller.v ----
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "lpm_regs.vh"

// Overview of operation
// - Each of four clock domains has its own independent division ratio field.
// - Every peripheral has its own stop bit that gates only that module.
// - Sleep, deep sleep and software standby modes halt CPU, peripherals or oscillators.
// - High, middle or low operating power setting applies in run, sleep, deep sleep.
// - Entry needs the control register programmed, then the halt instruction.
// - Only an interrupt wakes the device; CPU resumes in the handler.
// - In every reduced-power mode the CPU clock stops, state kept.
// - Main RAM runs in sleep; stopped with contents kept otherwise.
// - Transfer controller runs in sleep; stopped, state kept in deeper modes.
// - Flash keeps operating during sleep.
// - Flash is stopped with state kept in deep sleep and standby.
// - Standby stops main oscillator and PLL; sub and watchdog oscillators run.
// - Standby stops the low-speed on-chip oscillator.
// - Standby may keep the high-speed on-chip oscillator running.
// - Standby halts general peripherals with registers kept; other modes let them run.
// - Standby freezes I/O ports; sleep and deep sleep keep them running.
// - Watchdog, RTC, timers, detectors and clock outputs may run in all modes.
// - Remote control receivers may operate in every reduced-power mode.
// - Power-on reset circuit stays active in every mode.
// - Stop register A bit 19 halts the DAC.
// - Stop register C bits 29 and 28 halt remote receivers 0 and 1.
// - Reserved bits C[15:1] and D[7:0] read zero; software writes zero.
module low_power_mode_controller (
   input wire I_CLK,
   input wire I_RST_N,
   input wire I_AWVALID,
   output wire O_AWREADY,
   input wire [`LPM_ADDR_W-1:0] I_AWADDR,
   input wire [2:0] I_AWPROT,
   input wire I_WVALID,
   output wire O_WREADY,
   input wire [31:0] I_WDATA,
   input wire [3:0] I_WSTRB,
   output wire O_BVALID,
   input wire I_BREADY,
   output wire [1:0] O_BRESP,
   input wire I_ARVALID,
   output wire O_ARREADY,
   input wire [`LPM_ADDR_W-1:0] I_ARADDR,
   input wire [2:0] I_ARPROT,
   output wire O_RVALID,
   input wire I_RREADY,
   output wire [31:0] O_RDATA,
   output wire [1:0] O_RRESP,
   input wire I_HALT_INSN,
   input wire I_IRQ_WAKE,
   input wire I_STBY_WAKE,
   output reg O_RESUME_IRQ,
   output reg [1:0] O_LP_STATE,
   output reg [1:0] O_POWER_MODE,
   output reg O_SYS_CLK_EN,
   output reg O_CPU_CLK_EN,
   output reg O_PERIPH_CLK_EN,
   output reg O_CONV_CLK_EN,
   output reg O_FLASH_CLK_EN,
   output reg O_RAM_RUN,
   output reg O_DTC_RUN,
   output reg O_FLASH_RUN,
   output reg O_MAIN_OSC_EN,
   output reg O_PLL_EN,
   output reg O_LOCO_EN,
   output reg O_HOCO_EN,
   output reg O_SUB_OSC_EN,
   output reg O_INDEPENDENT_WATCHDOG_OSC_EN,
   output reg O_ALWAYS_ON_EN,
   output reg O_POR_EN,
   output reg O_IO_HOLD,
   output reg O_DAC_CLK_EN,
   output reg O_REMOTE_RX0_CLK_EN,
   output reg O_REMOTE_RX1_CLK_EN,
   output reg [31:0] O_MODULE_CLK_EN_A,
   output reg [31:0] O_MODULE_CLK_EN_B,
   output reg [31:0] O_MODULE_CLK_EN_C,
   output reg [31:0] O_MODULE_CLK_EN_D
);
   // Operating states of the sequencer.
   localparam ST_RUN = 2'h0;
   localparam ST_SLEEP = 2'h1;
   localparam ST_DEEP = 2'h2;
   localparam ST_STBY = 2'h3;

   // Register indices returned by the address decoder.
   localparam IDX_DIV = 3'h0;
   localparam IDX_CTRL = 3'h1;
   localparam IDX_STOP_A = 3'h2;
   localparam IDX_STOP_B = 3'h3;
   localparam IDX_STOP_C = 3'h4;
   localparam IDX_STOP_D = 3'h5;
   localparam IDX_STATUS = 3'h6;
   localparam IDX_NONE = 3'h7;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [31:0] clk_div_q;
   reg [31:0] lp_ctrl_q;
   reg [31:0] stop_a_q;
   reg [31:0] stop_b_q;
   reg [31:0] stop_c_q;
   reg [31:0] stop_d_q;
   reg [1:0] wake_src_q;
   reg awready_q;
   reg wready_q;
   reg aw_got_q;
   reg w_got_q;
   reg [`LPM_ADDR_W-1:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg arready_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   wire [3:0] div_tick;
   wire [3:0] div_run;
   wire [2:0] widx;
   wire [2:0] ridx;
   wire do_write;
   wire in_stby;
   wire [31:0] periph_mask;

   // Maps a byte address to a register index; misaligned or unknown gives none.
   function [2:0] decode;
      input [`LPM_ADDR_W-1:0] addr;
      begin
         case (addr)
            `LPM_OFF_CLK_DIV: decode = IDX_DIV;
            `LPM_OFF_LP_CTRL: decode = IDX_CTRL;
            `LPM_OFF_STOP_A: decode = IDX_STOP_A;
            `LPM_OFF_STOP_B: decode = IDX_STOP_B;
            `LPM_OFF_STOP_C: decode = IDX_STOP_C;
            `LPM_OFF_STOP_D: decode = IDX_STOP_D;
            `LPM_OFF_STATUS: decode = IDX_STATUS;
            default: decode = IDX_NONE;
         endcase
      end
   endfunction

   // Merges write data into an old value under the byte strobes and a writable mask.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      input [31:0] wmask;
      reg [31:0] lanes;
      begin
         lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
         merge = (old & ~(lanes & wmask)) | (data & lanes & wmask);
      end
   endfunction

   assign widx = decode(waddr_q);
   assign ridx = decode(I_ARADDR);
   assign do_write = aw_got_q && w_got_q && !bvalid_q;
   assign in_stby = (state_q == ST_STBY);

   // Bus outputs come straight from their flip-flops.
   assign O_AWREADY = awready_q;
   assign O_WREADY = wready_q;
   assign O_BVALID = bvalid_q;
   assign O_BRESP = bresp_q;
   assign O_ARREADY = arready_q;
   assign O_RVALID = rvalid_q;
   assign O_RDATA = rdata_q;
   assign O_RRESP = rresp_q;

   // Write channel: address and data are taken in either order, then answered.
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= {`LPM_ADDR_W{1'b0}};
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `LPM_RESP_OKAY;
      end
      else
      begin
         if (I_AWVALID && awready_q)
         begin
            awready_q <= 1'b0;
            aw_got_q <= 1'b1;
            waddr_q <= I_AWADDR;
         end
         if (I_WVALID && wready_q)
         begin
            wready_q <= 1'b0;
            w_got_q <= 1'b1;
            wdata_q <= I_WDATA;
            wstrb_q <= I_WSTRB;
         end
         if (do_write)
         begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (widx == IDX_NONE || widx == IDX_STATUS) ?
               `LPM_RESP_SLVERR : `LPM_RESP_OKAY;
         end
         if (bvalid_q && I_BREADY)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Software-visible registers; reserved stop bits are never stored.
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         clk_div_q <= `LPM_RST_CLK_DIV;
         lp_ctrl_q <= `LPM_RST_LP_CTRL;
         stop_a_q <= `LPM_RST_STOP_A;
         stop_b_q <= `LPM_RST_STOP_B;
         stop_c_q <= `LPM_RST_STOP_C;
         stop_d_q <= `LPM_RST_STOP_D;
      end
      else if (do_write)
      begin
         case (widx)
            IDX_DIV: clk_div_q <= merge(clk_div_q, wdata_q, wstrb_q, `LPM_DIV_MASK);
            IDX_CTRL:
            begin
               // An undefined power setting is ignored and the old one kept.
               if (wdata_q[`LPM_CTRL_PWR_LSB+1:`LPM_CTRL_PWR_LSB] == `LPM_PWR_BAD)
               begin
                  lp_ctrl_q <= merge(lp_ctrl_q, wdata_q, {wstrb_q[3:1], 1'b0},
                     `LPM_CTRL_MASK);
                  lp_ctrl_q[1:0] <= wstrb_q[0] ? wdata_q[1:0] : lp_ctrl_q[1:0];
               end
               else
               begin
                  lp_ctrl_q <= merge(lp_ctrl_q, wdata_q, wstrb_q, `LPM_CTRL_MASK);
               end
            end
            IDX_STOP_A: stop_a_q <= merge(stop_a_q, wdata_q, wstrb_q, 32'hFFFFFFFF);
            IDX_STOP_B: stop_b_q <= merge(stop_b_q, wdata_q, wstrb_q, 32'hFFFFFFFF);
            IDX_STOP_C: stop_c_q <= merge(stop_c_q, wdata_q, wstrb_q, ~`LPM_STOP_C_RSVD);
            IDX_STOP_D: stop_d_q <= merge(stop_d_q, wdata_q, wstrb_q, ~`LPM_STOP_D_RSVD);
            default: clk_div_q <= clk_div_q;
         endcase
      end
   end

   // Read channel: one read at a time, answered one cycle after the address.
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `LPM_RESP_OKAY;
      end
      else if (I_ARVALID && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= (ridx == IDX_NONE) ? `LPM_RESP_SLVERR : `LPM_RESP_OKAY;
         case (ridx)
            IDX_DIV: rdata_q <= clk_div_q;
            IDX_CTRL: rdata_q <= lp_ctrl_q;
            IDX_STOP_A: rdata_q <= stop_a_q;
            IDX_STOP_B: rdata_q <= stop_b_q;
            IDX_STOP_C: rdata_q <= stop_c_q & ~`LPM_STOP_C_RSVD;
            IDX_STOP_D: rdata_q <= stop_d_q & ~`LPM_STOP_D_RSVD;
            IDX_STATUS: rdata_q <= {26'h0000000, wake_src_q, 2'h0, state_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
      else if (rvalid_q && I_RREADY)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Next state: entry needs both the programmed target and the halt instruction.
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN:
         begin
            if (I_HALT_INSN)
            begin
               case (lp_ctrl_q[`LPM_CTRL_MODE_LSB+1:`LPM_CTRL_MODE_LSB])
                  `LPM_MODE_SLEEP: state_d = ST_SLEEP;
                  `LPM_MODE_DEEP: state_d = ST_DEEP;
                  `LPM_MODE_STBY: state_d = ST_STBY;
                  default: state_d = ST_SLEEP;
               endcase
            end
         end
         ST_SLEEP, ST_DEEP:
         begin
            if (I_IRQ_WAKE || I_STBY_WAKE)
            begin
               state_d = ST_RUN;
            end
         end
         ST_STBY:
         begin
            if (I_STBY_WAKE)
            begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   // State register, resume pulse to the interrupt path and the state last woken from.
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         state_q <= ST_RUN;
         O_RESUME_IRQ <= 1'b0;
         wake_src_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         O_RESUME_IRQ <= (state_q != ST_RUN) && (state_d == ST_RUN);
         if ((state_q != ST_RUN) && (state_d == ST_RUN))
         begin
            wake_src_q <= state_q;
         end
      end
   end

   // Divider run enables: converter and peripheral clocks stop in standby.
   assign div_run[0] = 1'b1;
   assign div_run[1] = !in_stby;
   assign div_run[2] = !in_stby;
   assign div_run[3] = !in_stby && (state_q != ST_DEEP);

   // One independent divider per clock domain.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_div
         clk_div_tick #(
            .CNT_W(7)
         ) u_div (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_run(div_run[gi]),
            .i_sel(clk_div_q[4*gi+`LPM_DIV_W-1:4*gi]),
            .o_tick(div_tick[gi])
         );
      end
   endgenerate

   // Peripheral clock gate shared by every general module.
   assign periph_mask = in_stby ? 32'h00000000 : 32'hFFFFFFFF;

   // Clock enables, run controls and module gates follow the registered state.
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_LP_STATE <= ST_RUN;
         O_POWER_MODE <= `LPM_PWR_HIGH;
         {O_SYS_CLK_EN, O_CPU_CLK_EN, O_PERIPH_CLK_EN, O_CONV_CLK_EN, O_FLASH_CLK_EN} <= 5'h00;
         {O_RAM_RUN, O_DTC_RUN, O_FLASH_RUN} <= 3'h7;
         {O_MAIN_OSC_EN, O_PLL_EN, O_LOCO_EN, O_HOCO_EN} <= 4'hF;
         {O_SUB_OSC_EN, O_INDEPENDENT_WATCHDOG_OSC_EN, O_ALWAYS_ON_EN, O_POR_EN} <= 4'hF;
         {O_IO_HOLD, O_DAC_CLK_EN, O_REMOTE_RX0_CLK_EN, O_REMOTE_RX1_CLK_EN} <= 4'h0;
         {O_MODULE_CLK_EN_A, O_MODULE_CLK_EN_B} <= 64'h0000000000000000;
         {O_MODULE_CLK_EN_C, O_MODULE_CLK_EN_D} <= 64'h0000000000000000;
      end
      else
      begin
         O_LP_STATE <= state_q;
         O_POWER_MODE <= lp_ctrl_q[`LPM_CTRL_PWR_LSB+1:`LPM_CTRL_PWR_LSB];
         O_SYS_CLK_EN <= div_tick[0];
         O_CPU_CLK_EN <= div_tick[0] && (state_q == ST_RUN);
         O_PERIPH_CLK_EN <= div_tick[1];
         O_CONV_CLK_EN <= div_tick[2];
         O_FLASH_CLK_EN <= div_tick[3];
         O_RAM_RUN <= div_run[3];
         O_DTC_RUN <= div_run[3];
         O_FLASH_RUN <= div_run[3];
         O_MAIN_OSC_EN <= !in_stby;
         O_PLL_EN <= !in_stby;
         O_LOCO_EN <= !in_stby;
         O_HOCO_EN <= !in_stby || lp_ctrl_q[`LPM_CTRL_HOCO_BIT];
         O_SUB_OSC_EN <= 1'b1;
         O_INDEPENDENT_WATCHDOG_OSC_EN <= 1'b1;
         O_ALWAYS_ON_EN <= 1'b1;
         O_POR_EN <= 1'b1;
         O_IO_HOLD <= in_stby;
         O_DAC_CLK_EN <= !stop_a_q[`LPM_DAC_STOP_BIT] && !in_stby;
         O_REMOTE_RX0_CLK_EN <= !stop_c_q[`LPM_RX0_STOP_BIT];
         O_REMOTE_RX1_CLK_EN <= !stop_c_q[`LPM_RX1_STOP_BIT];
         O_MODULE_CLK_EN_A <= ~stop_a_q & periph_mask;
         O_MODULE_CLK_EN_B <= ~stop_b_q & periph_mask;
         O_MODULE_CLK_EN_C <= ~stop_c_q & periph_mask;
         O_MODULE_CLK_EN_D <= ~stop_d_q & periph_mask;
      end
   end
endmodule

// ---- core/lpm_regs.vh ----
`ifndef LPM_REGS_VH
`define LPM_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define LPM_ADDR_W 8
`define LPM_OFF_CLK_DIV 8'h00
`define LPM_OFF_LP_CTRL 8'h04
`define LPM_OFF_STOP_A 8'h08
`define LPM_OFF_STOP_B 8'h0C
`define LPM_OFF_STOP_C 8'h10
`define LPM_OFF_STOP_D 8'h14
`define LPM_OFF_STATUS 8'h18

// Clock division register: four 3-bit fields, divide by two to the field value.
`define LPM_DIV_W 3
`define LPM_DIV_SYS_LSB 0
`define LPM_DIV_PERIPH_LSB 4
`define LPM_DIV_CONV_LSB 8
`define LPM_DIV_FLASH_LSB 12
`define LPM_DIV_MASK 32'h00007777

// Low-power control register fields.
`define LPM_CTRL_MODE_LSB 0
`define LPM_CTRL_PWR_LSB 4
`define LPM_CTRL_HOCO_BIT 8
`define LPM_CTRL_MASK 32'h00000133

// Reduced-power targets selected before the halt instruction.
`define LPM_MODE_SLEEP 2'h0
`define LPM_MODE_DEEP 2'h1
`define LPM_MODE_STBY 2'h2

// Operating power control settings.
`define LPM_PWR_HIGH 2'h0
`define LPM_PWR_MIDDLE 2'h1
`define LPM_PWR_LOW 2'h2
`define LPM_PWR_BAD 2'h3

// Reset values.
`define LPM_RST_CLK_DIV 32'h00000000
`define LPM_RST_LP_CTRL 32'h00000000
`define LPM_RST_STOP_A 32'hFFFFFFFF
`define LPM_RST_STOP_B 32'hFFFFFFFF
`define LPM_RST_STOP_C 32'hFFFF0001
`define LPM_RST_STOP_D 32'hFFFFFF00

// Reserved fields of stop registers C and D read as zero.
`define LPM_STOP_C_RSVD 32'h0000FFFE
`define LPM_STOP_D_RSVD 32'h000000FF

// Named stop bits.
`define LPM_DAC_STOP_BIT 19
`define LPM_RX1_STOP_BIT 28
`define LPM_RX0_STOP_BIT 29

// AXI response codes.
`define LPM_RESP_OKAY 2'h0
`define LPM_RESP_SLVERR 2'h2

`endif

// ---- core/clk_div_tick.v ----
`timescale 1ns/1ps
// Produces a one-cycle enable every 2**i_sel clocks while i_run is high.
module clk_div_tick #(
   parameter CNT_W = 7
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_run,
   input wire [2:0] i_sel,
   output reg o_tick
);
   reg [CNT_W-1:0] cnt_q;
   wire [CNT_W-1:0] mask;

   // Low bits of the counter that must all be set for a tick.
   assign mask = ~({CNT_W{1'b1}} << i_sel);

   // The counter freezes while stopped, so the phase resumes where it left off.
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= {CNT_W{1'b0}};
         o_tick <= 1'b0;
      end
      else
      begin
         if (i_run)
         begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         o_tick <= i_run && ((cnt_q & mask) == mask);
      end
   end
endmodule

// ---- bench/lpm_checker_props.sv ----
`timescale 1ns/1ps
module lpm_checker (
   input wire I_CLK,
   input wire I_RST_N,
   input wire I_HALT_INSN,
   input wire I_IRQ_WAKE,
   input wire I_STBY_WAKE,
   input wire O_CPU_CLK_EN,
   input wire O_RAM_RUN,
   input wire O_DTC_RUN,
   input wire O_FLASH_RUN,
   input wire O_MAIN_OSC_EN,
   input wire O_PLL_EN,
   input wire O_LOCO_EN,
   input wire O_POR_EN,
   input wire O_IO_HOLD,
   input wire O_DAC_CLK_EN,
   input wire O_REMOTE_RX0_CLK_EN,
   input wire O_REMOTE_RX1_CLK_EN,
   input wire [31:0] O_MODULE_CLK_EN_A,
   input wire [31:0] O_MODULE_CLK_EN_C
);
   reg [3:0] halt_age_q;
   reg [3:0] halt_age_d;
   reg [3:0] wake_age_q;
   reg [3:0] wake_age_d;

   // Ages of the last halt request and the last wake request, saturating at 15.
   always @*
   begin
      halt_age_d = I_HALT_INSN ? 4'h0 : halt_age_q + {3'h0, halt_age_q != 4'hF};
      wake_age_d = (I_IRQ_WAKE || I_STBY_WAKE) ? 4'h0 : wake_age_q + {3'h0, wake_age_q != 4'hF};
   end

   // The ages start from zero so that outputs settling after reset are not blamed.
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         halt_age_q <= 4'h0;
         wake_age_q <= 4'h0;
      end
      else
      begin
         halt_age_q <= halt_age_d;
         wake_age_q <= wake_age_d;
      end
   end

   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   property p_entry;
      $fell(O_DTC_RUN) |-> halt_age_q <= 4'h8;
   endproperty
   a_entry: assert property (p_entry) else $error("Deep entry without halt request");
   property p_wake;
      $rose(O_DTC_RUN) |-> wake_age_q <= 4'h8;
   endproperty
   a_wake: assert property (p_wake) else $error("Exit without wake request");
   property p_cpu_stop;
      O_IO_HOLD |-> !O_CPU_CLK_EN;
   endproperty
   a_cpu_stop: assert property (p_cpu_stop) else $error("CPU clock runs in standby");
   property p_ram_flash;
      O_RAM_RUN == O_FLASH_RUN;
   endproperty
   a_ram_flash: assert property (p_ram_flash) else $error("RAM and flash disagree");
   property p_dtc_flash;
      O_DTC_RUN == O_FLASH_RUN;
   endproperty
   a_dtc_flash: assert property (p_dtc_flash) else $error("DATA_TRANSFER_CONTROLLER and flash disagree");
   property p_stby_osc;
      O_IO_HOLD |-> !O_MAIN_OSC_EN && !O_PLL_EN;
   endproperty
   a_stby_osc: assert property (p_stby_osc) else $error("Main oscillator on in standby");
   property p_stby_loco;
      O_IO_HOLD |-> !O_LOCO_EN;
   endproperty
   a_stby_loco: assert property (p_stby_loco) else $error("Low-speed oscillator on");
   property p_por;
      O_POR_EN;
   endproperty
   a_por: assert property (p_por) else $error("Power-on reset circuit disabled");
   property p_dac;
      !O_IO_HOLD |-> O_DAC_CLK_EN == O_MODULE_CLK_EN_A[19];
   endproperty
   a_dac: assert property (p_dac) else $error("DAC enable not on stop bit 19");
   property p_rx;
      !O_IO_HOLD |-> {O_REMOTE_RX0_CLK_EN, O_REMOTE_RX1_CLK_EN} == O_MODULE_CLK_EN_C[29:28];
   endproperty
   a_rx: assert property (p_rx) else $error("Receiver enables not on bits 29 28");
endmodule

bind low_power_mode_controller lpm_checker u_lpm_checker (.I_CLK, .I_RST_N, .I_HALT_INSN,
   .I_IRQ_WAKE, .I_STBY_WAKE, .O_CPU_CLK_EN, .O_RAM_RUN, .O_DTC_RUN, .O_FLASH_RUN,
   .O_MAIN_OSC_EN, .O_PLL_EN, .O_LOCO_EN, .O_POR_EN, .O_IO_HOLD, .O_DAC_CLK_EN,
   .O_REMOTE_RX0_CLK_EN, .O_REMOTE_RX1_CLK_EN, .O_MODULE_CLK_EN_A, .O_MODULE_CLK_EN_C);

// ---- bench/low_power_mode_controller_test.sv ----
`timescale 1ns/1ps
`include "lpm_regs.vh"
module low_power_mode_controller_test;
   reg I_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
   reg I_HALT_INSN, I_IRQ_WAKE, I_STBY_WAKE;
   reg [`LPM_ADDR_W-1:0] I_AWADDR, I_ARADDR, a;
   reg [31:0] I_WDATA, rnd, v;
   reg [31:0] stp [0:3];
   reg [1:0] rsp;
   reg done, seen;
   integer fails, n_checks, i, m;
   wire O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_RESUME_IRQ, O_CPU_CLK_EN;
   wire [1:0] O_BRESP, O_RRESP, O_POWER_MODE;
   wire [31:0] O_RDATA, O_MODULE_CLK_EN_A, O_MODULE_CLK_EN_B, O_MODULE_CLK_EN_C, O_MODULE_CLK_EN_D;
   wire O_PERIPH_CLK_EN, O_RAM_RUN, O_DTC_RUN, O_FLASH_RUN, O_MAIN_OSC_EN, O_PLL_EN, O_LOCO_EN;
   wire O_HOCO_EN, O_ALWAYS_ON_EN, O_POR_EN, O_IO_HOLD, O_DAC_CLK_EN;
   wire O_REMOTE_RX0_CLK_EN, O_REMOTE_RX1_CLK_EN, O_SUB_OSC_EN, O_INDEPENDENT_WATCHDOG_OSC_EN;

   // Protection and strobe inputs stay at plain full-word values.
   low_power_mode_controller uut (.I_CLK, .I_RST_N, .I_AWVALID, .O_AWREADY, .I_AWADDR,
      .I_AWPROT(3'h0), .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB(4'hF), .O_BVALID, .I_BREADY,
      .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .I_ARPROT(3'h0), .O_RVALID, .I_RREADY,
      .O_RDATA, .O_RRESP, .I_HALT_INSN, .I_IRQ_WAKE, .I_STBY_WAKE, .O_RESUME_IRQ,
      .O_LP_STATE(), .O_POWER_MODE, .O_SYS_CLK_EN(), .O_CPU_CLK_EN, .O_PERIPH_CLK_EN,
      .O_CONV_CLK_EN(), .O_FLASH_CLK_EN(), .O_RAM_RUN, .O_DTC_RUN, .O_FLASH_RUN, .O_MAIN_OSC_EN,
      .O_PLL_EN, .O_LOCO_EN, .O_HOCO_EN, .O_SUB_OSC_EN, .O_INDEPENDENT_WATCHDOG_OSC_EN, .O_ALWAYS_ON_EN,
      .O_POR_EN, .O_IO_HOLD, .O_DAC_CLK_EN, .O_REMOTE_RX0_CLK_EN, .O_REMOTE_RX1_CLK_EN,
      .O_MODULE_CLK_EN_A, .O_MODULE_CLK_EN_B, .O_MODULE_CLK_EN_C, .O_MODULE_CLK_EN_D);

   // A 40 MHz clock.
   initial
   begin
      I_CLK = 1'b0;
      forever #12.5 I_CLK = ~I_CLK;
   end

   // Steps the pseudo-random sequence.
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   // Read-back of a stop register, with its reserved bits cleared.
   function [31:0] stop_exp(input [7:0] r, input [31:0] d);
      stop_exp = (r == `LPM_OFF_STOP_C) ? d & ~`LPM_STOP_C_RSVD :
         (r == `LPM_OFF_STOP_D) ? d & ~`LPM_STOP_D_RSVD : d;
   endfunction

   // Compares one value and reports a mismatch at once.
   task chk(input string name, input [31:0] exp, input [31:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
         end
      end
   endtask

   // One AXI write; address and data are offered together and dropped once taken.
   task wr(input [7:0] r, input [31:0] d);
      integer n;
      begin
         I_AWADDR <= r;
         I_WDATA <= d;
         I_AWVALID <= 1'b1;
         I_WVALID <= 1'b1;
         I_BREADY <= 1'b1;
         done = 1'b0;
         for (n = 0; n < 200 && !done; n = n + 1)
         begin
            @(posedge I_CLK);
            if (I_AWVALID && O_AWREADY)
               I_AWVALID <= 1'b0;
            if (I_WVALID && O_WREADY)
               I_WVALID <= 1'b0;
            if (O_BVALID)
            begin
               rsp = O_BRESP;
               I_BREADY <= 1'b0;
               done = 1'b1;
            end
         end
         chk("write_done", 1, done);
         @(posedge I_CLK);
      end
   endtask

   // One AXI read.
   task rd(input [7:0] r, output [31:0] d);
      integer n;
      begin
         I_ARADDR <= r;
         I_ARVALID <= 1'b1;
         I_RREADY <= 1'b1;
         done = 1'b0;
         for (n = 0; n < 200 && !done; n = n + 1)
         begin
            @(posedge I_CLK);
            if (I_ARVALID && O_ARREADY)
               I_ARVALID <= 1'b0;
            if (O_RVALID)
            begin
               d = O_RDATA;
               rsp = O_RRESP;
               I_RREADY <= 1'b0;
               done = 1'b1;
            end
         end
         chk("read_done", 1, done);
         @(posedge I_CLK);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task conclude;
      begin
         $display("Checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #(25.0 * 20000);
      fails = fails + 1;
      conclude;
   end

   // Main sequence.
   initial
   begin
      {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
      {I_HALT_INSN, I_IRQ_WAKE, I_STBY_WAKE} = 3'h0;
      {I_AWADDR, I_ARADDR, I_WDATA} = 48'h0;
      {fails, n_checks} = 64'h0;
      rnd = 32'h4435A519;
      I_RST_N = 1'b0;
      repeat (20) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      @(posedge I_CLK);
      stp[0] = `LPM_RST_STOP_A;
      stp[1] = `LPM_RST_STOP_B;
      stp[2] = `LPM_RST_STOP_C;
      stp[3] = `LPM_RST_STOP_D;
      rd(`LPM_OFF_CLK_DIV, v);
      chk("clk_div_reset", `LPM_RST_CLK_DIV, v);
      rd(`LPM_OFF_LP_CTRL, v);
      chk("lp_ctrl_reset", `LPM_RST_LP_CTRL, v);
      // Stop registers: reset values, then an all-zero write to A, all-one writes to B, C and D, and random writes to all four.
      for (i = 0; i < 12; i = i + 1)
      begin
         rnd = lfsr(rnd);
         a = `LPM_OFF_STOP_A + 8'(4 * (i % 4));
         if (i >= 4)
         begin
            v = (i == 4) ? 32'h00000000 : (i < 8) ? 32'hFFFFFFFF : rnd;
            wr(a, v);
            stp[i % 4] = stop_exp(a, v);
         end
         rd(a, v);
         chk("stop_read", stp[i % 4], v);
         repeat (4) @(posedge I_CLK);
         chk("clk_en_a", ~stp[0], O_MODULE_CLK_EN_A);
         chk("clk_en_b", ~stp[1], O_MODULE_CLK_EN_B);
         chk("clk_en_c", ~stp[2], O_MODULE_CLK_EN_C);
         chk("clk_en_d", ~stp[3], O_MODULE_CLK_EN_D);
         chk("dac_en", !stp[0][19], O_DAC_CLK_EN);
         chk("rx_en", {!stp[2][29], !stp[2][28]}, {O_REMOTE_RX0_CLK_EN, O_REMOTE_RX1_CLK_EN});
      end
      // Independent division fields.
      for (i = 0; i < 4; i = i + 1)
      begin
         rnd = lfsr(rnd);
         wr(`LPM_OFF_CLK_DIV, rnd);
         rd(`LPM_OFF_CLK_DIV, v);
         chk("clk_div", rnd & `LPM_DIV_MASK, v);
      end
      wr(`LPM_OFF_CLK_DIV, `LPM_RST_CLK_DIV);
      // Every operating power setting.
      for (m = 0; m < 3; m = m + 1)
      begin
         wr(`LPM_OFF_LP_CTRL, 32'(m) << `LPM_CTRL_PWR_LSB);
         repeat (4) @(posedge I_CLK);
         chk("power_mode", m, O_POWER_MODE);
      end
      // Each reduced-power mode: entry, state of each resource except the DAC, receiver 1 and module gates, wake-up.
      for (m = 0; m < 3; m = m + 1)
      begin
         wr(`LPM_OFF_LP_CTRL, (32'(m) << `LPM_CTRL_MODE_LSB) | (32'h1 << `LPM_CTRL_HOCO_BIT));
         repeat (8) @(posedge I_CLK);
         chk("no_entry", 1, O_CPU_CLK_EN);
         I_HALT_INSN <= 1'b1;
         @(posedge I_CLK);
         I_HALT_INSN <= 1'b0;
         for (i = 0; i < 50 && O_CPU_CLK_EN !== 1'b0; i = i + 1)
            @(posedge I_CLK);
         repeat (2) @(posedge I_CLK);
         chk("cpu_clk", 0, O_CPU_CLK_EN);
         chk("ram_run", m == `LPM_MODE_SLEEP, O_RAM_RUN);
         chk("dtc_run", m == `LPM_MODE_SLEEP, O_DTC_RUN);
         chk("flash_run", m == `LPM_MODE_SLEEP, O_FLASH_RUN);
         chk("osc_pll", {2{m != `LPM_MODE_STBY}}, {O_MAIN_OSC_EN, O_PLL_EN});
         chk("sub_independent_watchdog", 3, {O_SUB_OSC_EN, O_INDEPENDENT_WATCHDOG_OSC_EN});
         chk("loco", m != `LPM_MODE_STBY, O_LOCO_EN);
         chk("hoco", 1, O_HOCO_EN);
         chk("periph", m != `LPM_MODE_STBY, O_PERIPH_CLK_EN);
         chk("io_hold", m == `LPM_MODE_STBY, O_IO_HOLD);
         chk("always_on", 1, O_ALWAYS_ON_EN);
         chk("remote_rx0", !stp[2][29], O_REMOTE_RX0_CLK_EN);
         chk("por", 1, O_POR_EN);
         I_IRQ_WAKE <= 1'b1;
         I_STBY_WAKE <= 1'b1;
         @(posedge I_CLK);
         I_IRQ_WAKE <= 1'b0;
         I_STBY_WAKE <= 1'b0;
         seen = 1'b0;
         for (i = 0; i < 50 && O_CPU_CLK_EN !== 1'b1; i = i + 1)
         begin
            @(posedge I_CLK);
            seen = seen | O_RESUME_IRQ;
         end
         @(posedge I_CLK);
         seen = seen | O_RESUME_IRQ;
         chk("resume", 3, {seen, O_CPU_CLK_EN});
         rd(`LPM_OFF_STOP_A, v);
         chk("stop_kept", stp[0], v);
      end
      // Unmapped address on both channels.
      wr(8'h40, 32'h00000000);
      chk("bresp", `LPM_RESP_SLVERR, rsp);
      rd(8'h40, v);
      chk("rresp", `LPM_RESP_SLVERR, rsp);
      conclude;
   end
endmodule
